// >>> tws_defs.svh
`ifndef TWS_DEFS_SVH
`define TWS_DEFS_SVH

// Status codes reported with the done flag
`define TWS_CODE_START        8'h08
`define TWS_CODE_REP_START    8'h10
`define TWS_CODE_MTX_ADR_ACK  8'h18
`define TWS_CODE_MTX_ADR_NACK 8'h20
`define TWS_CODE_MTX_DAT_ACK  8'h28
`define TWS_CODE_MTX_DAT_NACK 8'h30
`define TWS_CODE_MRX_ADR_ACK  8'h40
`define TWS_CODE_MRX_ADR_NACK 8'h48
`define TWS_CODE_MRX_DAT_ACK  8'h50
`define TWS_CODE_MRX_DAT_NACK 8'h58
`define TWS_CODE_SRX_ADR_ACK  8'h60
`define TWS_CODE_SRX_DAT_ACK  8'h80
`define TWS_CODE_SRX_DAT_NACK 8'h88
`define TWS_CODE_SRX_STOP     8'ha0
`define TWS_CODE_STX_ADR_ACK  8'ha8
`define TWS_CODE_STX_DAT_ACK  8'hb8
`define TWS_CODE_STX_DAT_NACK 8'hc0

// Prescaler bits of the status byte read as zero
`define TWS_STATUS_MASK       8'hf8

// Reset values
`define TWS_BYTE_RST          8'h00
`define TWS_CODE_RST          8'hf8

// Bit timing: eight link clock phases per bus bit
`define TWS_PH_SDA            3'd0
`define TWS_PH_SCL_UP         3'd2
`define TWS_PH_MID            3'd4
`define TWS_PH_SAMPLE         3'd6
`define TWS_PH_LAST           3'd7
`define TWS_PH_STEP           3'd1
`define TWS_PH_RST            3'd0

// Bit counter: eight data bits, then the acknowledge bit
`define TWS_BIT_FIRST         4'd0
`define TWS_BIT_ACK           4'd8
`define TWS_BIT_DONE          4'd9
`define TWS_BIT_STEP          4'd1

// Synchroniser lane counts
`define TWS_LK_SYNC_N         5
`define TWS_CK_SYNC_N         2

`endif

// >>> tws_pkg.sv
package tws_pkg;

   typedef logic [7:0] tws_byte_t;
   typedef logic [6:0] tws_addr_t;

   typedef enum logic [2:0] {
      L_IDLE,
      L_START,
      L_STOP,
      L_MBIT,
      L_SBIT,
      L_WAIT
   } tws_link_st_t;

endpackage

// >>> tws_sync.sv
`timescale 1ns/1ps
module tws_sync (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic din,
   output logic      dout
);
   logic [2:0] s_q;
   logic [2:0] s_d;
   logic       out_q;
   logic       out_d;

   // Three stages; output moves once stages two and three agree
   always_comb begin
      s_d   = {s_q[1:0], din};
      out_d = (s_q[1] == s_q[2]) ? s_q[2] : out_q;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q   <= 3'h0;
         out_q <= 1'b0;
      end else begin
         s_q   <= s_d;
         out_q <= out_d;
      end
   end

   assign dout = out_q;
endmodule

// >>> tws_core.sv
// Functional notes
// - Supports master transmit, master receive, slave transmit and slave receive roles.
// - Direction bit after an address: high means read, low means write.
// - Acknowledge is a low data line; not-acknowledge is high.
// - Every packet is eight data bits plus one acknowledge bit.
// - Done flag set presents a status code, prescaler bits read as zero.
// - While the done flag is set, bus activity is suspended.
// - Done flag sets after a byte and its acknowledge bit are done.
// - Writing one to the done flag clears it and launches the action.
// - Clear, enable and stop-request with start clear drive a stop condition only while the block is master; idle and slave roles drive none.
// - After a requested start outside the slave role, done flag sets with the start code, or the repeated-start code while the block already owns the bus.
// - Data write while the done flag is low is dropped, sets collision flag.
`timescale 1ns/1ps
`include "tws_defs.svh"
module tws_core (
   input  wire logic           CLK,
   input  wire logic           RST_N,
   input  wire logic           LINK_CLK,
   input  wire logic           CTRL_WR,
   input  wire logic           CTRL_CLEAR,
   input  wire logic           CTRL_START_REQUEST_BIT,
   input  wire logic           CTRL_STOP,
   input  wire logic           CTRL_ACK_EN,
   input  wire logic           CTRL_ENABLE,
   input  wire logic           DATA_WR,
   input  wire tws_pkg::tws_byte_t DATA_IN,
   input  wire tws_pkg::tws_addr_t OWN_ADDR,
   output tws_pkg::tws_byte_t  DATA_OUT,
   output tws_pkg::tws_byte_t  BUS_STATUS_REGISTER,
   output logic                DONE_FLAG,
   output logic                WRITE_COLLISION_FLAG,
   output logic                STOP_PENDING,
   input  wire logic           SCL_I,
   output logic                SCL_O,
   output logic                SCL_OE,
   input  wire logic           SDA_I,
   output logic                SDA_O,
   output logic                SDA_OE
);
   import tws_pkg::*;

   // System clock domain state
   tws_byte_t    data_shift_register_q, data_shift_register_d;
   tws_byte_t    bus_status_register_q, bus_status_register_d;
   logic         flag_q, flag_d;
   logic         write_collision_flag_q, write_collision_flag_d;
   logic         start_request_bit_q, start_request_bit_d;
   logic         stop_q, stop_d;
   logic         ack_en_q, ack_en_d;
   logic         en_q, en_d;
   logic         busy_q, busy_d;
   logic         cmd_tgl_q, cmd_tgl_d;
   logic         done_seen_q, done_seen_d;
   logic         quiet_seen_q, quiet_seen_d;

   // Link domain state
   tws_link_st_t ls_q, ls_d;
   logic [2:0]   ph_q, ph_d;
   logic [3:0]   bc_q, bc_d;
   tws_byte_t    sh_q, sh_d;
   tws_byte_t    code_q, code_d;
   logic         done_tgl_q, done_tgl_d;
   logic         quiet_tgl_q, quiet_tgl_d;
   logic         cmd_ack_q, cmd_ack_d;
   logic         scl_oe_q, scl_oe_d;
   logic         sda_oe_q, sda_oe_d;
   logic         m_act_q, m_act_d;
   logic         m_adr_q, m_adr_d;
   logic         m_rd_q, m_rd_d;
   logic         slv_q, slv_d;
   logic         s_adr_q, s_adr_d;
   logic         s_tx_q, s_tx_d;
   logic         s_end_q, s_end_d;
   logic         ack_q, ack_d;
   logic         scl_p_q, scl_p_d;
   logic         sda_p_q, sda_p_d;

   logic [`TWS_LK_SYNC_N-1:0] lk_in, lk_s;
   logic [`TWS_CK_SYNC_N-1:0] ck_in, ck_s;
   logic         sda_s, scl_s, cmd_s, en_s, ea_s, done_s, quiet_s;
   logic         clear, launch, done_evt, quiet_evt, cmd_pend, m_tx, adr_hit;
   logic         rpt;
   tws_byte_t    rpt_code;

   // Code after a master byte and its acknowledge bit
   function automatic tws_byte_t master_code(input logic adr, input logic rd,
                                             input logic ack);
      if (adr)
         master_code = rd ? (ack ? `TWS_CODE_MRX_ADR_ACK : `TWS_CODE_MRX_ADR_NACK)
                          : (ack ? `TWS_CODE_MTX_ADR_ACK : `TWS_CODE_MTX_ADR_NACK);
      else
         master_code = rd ? (ack ? `TWS_CODE_MRX_DAT_ACK : `TWS_CODE_MRX_DAT_NACK)
                          : (ack ? `TWS_CODE_MTX_DAT_ACK : `TWS_CODE_MTX_DAT_NACK);
   endfunction

   // Code after a slave byte and its acknowledge bit
   function automatic tws_byte_t slave_code(input logic adr, input logic rd,
                                            input logic tx, input logic ack);
      if (adr)
         slave_code = rd ? `TWS_CODE_STX_ADR_ACK : `TWS_CODE_SRX_ADR_ACK;
      else if (tx)
         slave_code = ack ? `TWS_CODE_STX_DAT_ACK : `TWS_CODE_STX_DAT_NACK;
      else
         slave_code = ack ? `TWS_CODE_SRX_DAT_ACK : `TWS_CODE_SRX_DAT_NACK;
   endfunction

   // Crossings: pins and control levels into the link domain, toggles back
   assign lk_in = {SDA_I, SCL_I, cmd_tgl_q, en_q, ack_en_q};
   assign ck_in = {quiet_tgl_q, done_tgl_q};

   genvar gi;
   generate
      for (gi = 0; gi < `TWS_LK_SYNC_N; gi = gi + 1) begin : g_lk
         tws_sync u_sync (.clk(LINK_CLK), .rst_n(RST_N), .din(lk_in[gi]), .dout(lk_s[gi]));
      end
      for (gi = 0; gi < `TWS_CK_SYNC_N; gi = gi + 1) begin : g_ck
         tws_sync u_sync (.clk(CLK), .rst_n(RST_N), .din(ck_in[gi]), .dout(ck_s[gi]));
      end
   endgenerate

   assign {sda_s, scl_s, cmd_s, en_s, ea_s} = lk_s;
   assign {quiet_s, done_s} = ck_s;

   // Register side events
   assign clear     = CTRL_WR & CTRL_CLEAR;
   assign launch    = clear & CTRL_ENABLE & (flag_q | ~busy_q);
   assign done_evt  = done_s ^ done_seen_q;
   assign quiet_evt = quiet_s ^ quiet_seen_q;

   // Register side next state
   always_comb begin
      data_shift_register_d  = data_shift_register_q;
      bus_status_register_d  = bus_status_register_q;
      write_collision_flag_d = write_collision_flag_q;
      start_request_bit_d    = start_request_bit_q;
      stop_d                 = stop_q;
      ack_en_d               = ack_en_q;
      en_d                   = en_q;
      done_seen_d            = done_s;
      quiet_seen_d           = quiet_s;
      cmd_tgl_d              = cmd_tgl_q ^ launch;
      flag_d                 = done_evt | (flag_q & ~clear);
      busy_d                 = launch | (busy_q & en_q & ~done_evt & ~quiet_evt);
      if (CTRL_WR) begin
         en_d     = CTRL_ENABLE;
         ack_en_d = CTRL_ACK_EN;
         if (launch | ~busy_q) begin
            start_request_bit_d = CTRL_START_REQUEST_BIT;
            stop_d              = CTRL_STOP;
         end
      end
      if (done_evt | quiet_evt)
         stop_d = 1'b0;
      if (done_evt) begin
         bus_status_register_d = code_q & `TWS_STATUS_MASK;
         data_shift_register_d = sh_q;
      end else if (DATA_WR & flag_q) begin
         data_shift_register_d  = DATA_IN;
         write_collision_flag_d = 1'b0;
      end
      if (DATA_WR & ~flag_q)
         write_collision_flag_d = 1'b1;
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         data_shift_register_q  <= `TWS_BYTE_RST;
         bus_status_register_q  <= `TWS_CODE_RST;
         flag_q                 <= 1'b0;
         write_collision_flag_q <= 1'b0;
         start_request_bit_q    <= 1'b0;
         stop_q                 <= 1'b0;
         ack_en_q               <= 1'b0;
         en_q                   <= 1'b0;
         busy_q                 <= 1'b0;
         cmd_tgl_q              <= 1'b0;
         done_seen_q            <= 1'b0;
         quiet_seen_q           <= 1'b0;
      end else begin
         data_shift_register_q  <= data_shift_register_d;
         bus_status_register_q  <= bus_status_register_d;
         flag_q                 <= flag_d;
         write_collision_flag_q <= write_collision_flag_d;
         start_request_bit_q    <= start_request_bit_d;
         stop_q                 <= stop_d;
         ack_en_q               <= ack_en_d;
         en_q                   <= en_d;
         busy_q                 <= busy_d;
         cmd_tgl_q              <= cmd_tgl_d;
         done_seen_q            <= done_seen_d;
         quiet_seen_q           <= quiet_seen_d;
      end
   end

   // Link side decodes; command fields stay still while a command is pending
   assign cmd_pend = cmd_s ^ cmd_ack_q;
   assign m_tx     = m_adr_q | ~m_rd_q;
   assign adr_hit  = (sh_q[7:1] == OWN_ADDR);

   // Link side next state
   always_comb begin
      ls_d        = ls_q;
      ph_d        = ph_q + `TWS_PH_STEP;
      bc_d        = bc_q;
      sh_d        = sh_q;
      code_d      = code_q;
      done_tgl_d  = done_tgl_q;
      quiet_tgl_d = quiet_tgl_q;
      cmd_ack_d   = cmd_ack_q;
      scl_oe_d    = scl_oe_q;
      sda_oe_d    = sda_oe_q;
      m_act_d     = m_act_q;
      m_adr_d     = m_adr_q;
      m_rd_d      = m_rd_q;
      slv_d       = slv_q;
      s_adr_d     = s_adr_q;
      s_tx_d      = s_tx_q;
      s_end_d     = s_end_q;
      ack_d       = ack_q;
      scl_p_d     = scl_s;
      sda_p_d     = sda_s;
      rpt         = 1'b0;
      rpt_code    = code_q;
      if (!en_s) begin
         ls_d     = L_IDLE;
         scl_oe_d = 1'b0;
         sda_oe_d = 1'b0;
         m_act_d  = 1'b0;
         slv_d    = 1'b0;
      end else begin
         unique case (ls_q)
            L_IDLE: begin
               if (cmd_pend) begin
                  cmd_ack_d = cmd_s;
                  ph_d      = `TWS_PH_RST;
                  if (start_request_bit_q)
                     ls_d = L_START;
                  else
                     quiet_tgl_d = ~quiet_tgl_q;
               end else if (scl_s && sda_p_q && !sda_s) begin
                  ls_d    = L_SBIT;
                  slv_d   = 1'b1;
                  s_adr_d = 1'b1;
                  s_tx_d  = 1'b0;
                  s_end_d = 1'b0;
                  bc_d    = `TWS_BIT_FIRST;
               end
            end
            L_START: begin
               if (ph_q == `TWS_PH_SDA)
                  sda_oe_d = 1'b0;
               else if (ph_q == `TWS_PH_SCL_UP)
                  scl_oe_d = 1'b0;
               else if (ph_q == `TWS_PH_MID)
                  sda_oe_d = 1'b1;
               else if (ph_q == `TWS_PH_LAST) begin
                  scl_oe_d = 1'b1;
                  rpt      = 1'b1;
                  rpt_code = m_act_q ? `TWS_CODE_REP_START : `TWS_CODE_START;
                  m_act_d  = 1'b1;
                  m_adr_d  = 1'b1;
               end
            end
            L_STOP: begin
               if (ph_q == `TWS_PH_SDA)
                  sda_oe_d = 1'b1;
               else if (ph_q == `TWS_PH_SCL_UP)
                  scl_oe_d = 1'b0;
               else if (ph_q == `TWS_PH_MID)
                  sda_oe_d = 1'b0;
               else if (ph_q == `TWS_PH_LAST) begin
                  m_act_d = 1'b0;
                  if (start_request_bit_q)
                     ls_d = L_START;
                  else begin
                     ls_d        = L_IDLE;
                     quiet_tgl_d = ~quiet_tgl_q;
                  end
               end
            end
            L_MBIT: begin
               if (ph_q == `TWS_PH_SDA) begin
                  if (bc_q < `TWS_BIT_ACK)
                     sda_oe_d = m_tx & ~sh_q[7];
                  else
                     sda_oe_d = ~m_tx & ea_s;
               end else if (ph_q == `TWS_PH_SCL_UP)
                  scl_oe_d = 1'b0;
               else if (ph_q == `TWS_PH_SAMPLE) begin
                  if (bc_q < `TWS_BIT_ACK)
                     sh_d = {sh_q[6:0], sda_s};
                  else
                     ack_d = ~sda_s;
               end else if (ph_q == `TWS_PH_LAST) begin
                  scl_oe_d = 1'b1;
                  bc_d     = bc_q + `TWS_BIT_STEP;
                  if (bc_q == `TWS_BIT_ACK) begin
                     rpt      = 1'b1;
                     rpt_code = master_code(m_adr_q, m_rd_q, ack_q);
                     m_adr_d  = 1'b0;
                  end
               end
            end
            L_WAIT: begin
               if (cmd_pend) begin
                  cmd_ack_d = cmd_s;
                  ph_d      = `TWS_PH_RST;
                  bc_d      = `TWS_BIT_FIRST;
                  sh_d      = data_shift_register_q;
                  if (slv_q) begin
                     if (s_end_q) begin
                        ls_d        = L_IDLE;
                        quiet_tgl_d = ~quiet_tgl_q;
                        slv_d    = 1'b0;
                        scl_oe_d = 1'b0;
                        sda_oe_d = 1'b0;
                     end else begin
                        ls_d     = L_SBIT;
                        scl_oe_d = 1'b0;
                        sda_oe_d = s_tx_q & ~data_shift_register_q[7];
                        s_adr_d  = 1'b0;
                     end
                  end else if (stop_q)
                     ls_d = L_STOP;
                  else if (start_request_bit_q)
                     ls_d = L_START;
                  else begin
                     ls_d = L_MBIT;
                     if (m_adr_q)
                        m_rd_d = data_shift_register_q[0];
                  end
               end
            end
            L_SBIT: begin
               if (scl_s && !sda_p_q && sda_s) begin
                  rpt      = 1'b1;
                  rpt_code = `TWS_CODE_SRX_STOP;
                  s_end_d  = 1'b1;
                  scl_oe_d = 1'b0;
                  sda_oe_d = 1'b0;
               end else if (scl_s && sda_p_q && !sda_s) begin
                  bc_d     = `TWS_BIT_FIRST;
                  s_adr_d  = 1'b1;
                  s_tx_d   = 1'b0;
                  sda_oe_d = 1'b0;
               end else if (scl_p_q && !scl_s) begin
                  if (bc_q == `TWS_BIT_DONE) begin
                     sda_oe_d = 1'b0;
                     if (s_adr_q && !adr_hit) begin
                        ls_d  = L_IDLE;
                        slv_d = 1'b0;
                     end else begin
                        rpt      = 1'b1;
                        rpt_code = slave_code(s_adr_q, sh_q[0], s_tx_q, ack_q);
                        scl_oe_d = 1'b1;
                        if (s_adr_q)
                           s_tx_d = sh_q[0];
                     end
                  end else if (bc_q == `TWS_BIT_ACK)
                     sda_oe_d = ~s_tx_q & (s_adr_q ? adr_hit : ea_s);
                  else
                     sda_oe_d = s_tx_q & ~sh_q[7];
               end else if (!scl_p_q && scl_s) begin
                  bc_d = bc_q + `TWS_BIT_STEP;
                  if (bc_q < `TWS_BIT_ACK)
                     sh_d = {sh_q[6:0], sda_s};
                  else
                     ack_d = ~sda_s;
               end
            end
         endcase
      end
      // Every report suspends the bus; the clock line stays as held
      if (rpt) begin
         code_d     = rpt_code;
         done_tgl_d = ~done_tgl_q;
         ls_d       = L_WAIT;
      end
   end

   always_ff @(posedge LINK_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ls_q        <= L_IDLE;
         ph_q        <= `TWS_PH_RST;
         bc_q        <= `TWS_BIT_FIRST;
         sh_q        <= `TWS_BYTE_RST;
         code_q      <= `TWS_CODE_RST;
         done_tgl_q  <= 1'b0;
         quiet_tgl_q <= 1'b0;
         cmd_ack_q   <= 1'b0;
         scl_oe_q    <= 1'b0;
         sda_oe_q    <= 1'b0;
         m_act_q     <= 1'b0;
         m_adr_q     <= 1'b0;
         m_rd_q      <= 1'b0;
         slv_q       <= 1'b0;
         s_adr_q     <= 1'b0;
         s_tx_q      <= 1'b0;
         s_end_q     <= 1'b0;
         ack_q       <= 1'b0;
         scl_p_q     <= 1'b1;
         sda_p_q     <= 1'b1;
      end else begin
         ls_q        <= ls_d;
         ph_q        <= ph_d;
         bc_q        <= bc_d;
         sh_q        <= sh_d;
         code_q      <= code_d;
         done_tgl_q  <= done_tgl_d;
         quiet_tgl_q <= quiet_tgl_d;
         cmd_ack_q   <= cmd_ack_d;
         scl_oe_q    <= scl_oe_d;
         sda_oe_q    <= sda_oe_d;
         m_act_q     <= m_act_d;
         m_adr_q     <= m_adr_d;
         m_rd_q      <= m_rd_d;
         slv_q       <= slv_d;
         s_adr_q     <= s_adr_d;
         s_tx_q      <= s_tx_d;
         s_end_q     <= s_end_d;
         ack_q       <= ack_d;
         scl_p_q     <= scl_p_d;
         sda_p_q     <= sda_p_d;
      end
   end

   // Outputs; open-drain pins only ever pull low
   assign DATA_OUT             = data_shift_register_q;
   assign BUS_STATUS_REGISTER  = bus_status_register_q;
   assign DONE_FLAG            = flag_q;
   assign WRITE_COLLISION_FLAG = write_collision_flag_q;
   assign STOP_PENDING         = stop_q;
   assign SCL_O                = 1'b0;
   assign SCL_OE               = scl_oe_q;
   assign SDA_O                = 1'b0;
   assign SDA_OE               = sda_oe_q;
endmodule

// >>> tws_core_properties.sv
`timescale 1ns/1ps
module tws_core_properties (
   input wire logic               CLK,
   input wire logic               RST_N,
   input wire logic               CTRL_WR,
   input wire logic               CTRL_CLEAR,
   input wire logic               CTRL_START_REQUEST_BIT,
   input wire logic               CTRL_STOP,
   input wire logic               CTRL_ENABLE,
   input wire logic               DATA_WR,
   input wire tws_pkg::tws_byte_t DATA_IN,
   input wire tws_pkg::tws_byte_t DATA_OUT,
   input wire tws_pkg::tws_byte_t BUS_STATUS_REGISTER,
   input wire logic               DONE_FLAG,
   input wire logic               WRITE_COLLISION_FLAG,
   input wire logic               STOP_PENDING,
   input wire logic               SCL_OE,
   input wire logic               SDA_OE
);
   import tws_pkg::*;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // Stop request written while suspended
   sequence s_stop_req;
      CTRL_WR && CTRL_CLEAR && CTRL_ENABLE && CTRL_STOP && !CTRL_START_REQUEST_BIT && DONE_FLAG;
   endsequence
   sequence s_stop_done;
      STOP_PENDING ##[0:300] !STOP_PENDING;
   endsequence
   property p_low_zero;
      BUS_STATUS_REGISTER[2:0] == 3'h0;
   endproperty
   property p_clear;
      CTRL_WR && CTRL_CLEAR && DONE_FLAG |=> !DONE_FLAG;
   endproperty
   property p_wcol;
      DATA_WR && !DONE_FLAG |=> WRITE_COLLISION_FLAG && $stable(DATA_OUT);
   endproperty
   property p_load;
      DATA_WR && DONE_FLAG |=> DATA_OUT == $past(DATA_IN) && !WRITE_COLLISION_FLAG;
   endproperty
   property p_hold;
      DONE_FLAG && !(CTRL_WR && CTRL_CLEAR) |=> $stable(BUS_STATUS_REGISTER);
   endproperty
   property p_rose_code;
      $rose(DONE_FLAG) |-> BUS_STATUS_REGISTER != 8'hf8;
   endproperty
   property p_stop_go;
      s_stop_req |=> s_stop_done;
   endproperty
   property p_quiet;
      DONE_FLAG [*8] |=> $stable(SCL_OE) && $stable(SDA_OE);
   endproperty
   a_low_zero: assert property (p_low_zero) else $error("status low bits set");
   a_clear: assert property (p_clear) else $error("flag not cleared");
   a_wcol: assert property (p_wcol) else $error("collision not flagged");
   a_load: assert property (p_load) else $error("data byte not loaded");
   a_hold: assert property (p_hold) else $error("status moved");
   a_rose_code: assert property (p_rose_code) else $error("flag without code");
   a_stop_go: assert property (p_stop_go) else $error("stop not carried out");
   a_quiet: assert property (p_quiet) else $error("bus moved while suspended");
endmodule

bind tws_core tws_core_properties i_props (.CLK(CLK), .RST_N(RST_N), .CTRL_WR(CTRL_WR),
   .CTRL_CLEAR(CTRL_CLEAR), .CTRL_START_REQUEST_BIT(CTRL_START_REQUEST_BIT),
   .CTRL_STOP(CTRL_STOP), .CTRL_ENABLE(CTRL_ENABLE), .DATA_WR(DATA_WR), .DATA_IN(DATA_IN),
   .DATA_OUT(DATA_OUT), .BUS_STATUS_REGISTER(BUS_STATUS_REGISTER), .DONE_FLAG(DONE_FLAG),
   .WRITE_COLLISION_FLAG(WRITE_COLLISION_FLAG), .STOP_PENDING(STOP_PENDING),
   .SCL_OE(SCL_OE), .SDA_OE(SDA_OE));

// >>> tws_target_model.sv
`timescale 1ns/1ps
module tws_target_model #(parameter logic [6:0] ADDR = 7'h52) (
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic [7:0] tx_byte,
   output logic            sda_oe,
   output logic [7:0]      rx_byte
);
   logic [7:0] sh, tx_sh;
   logic       sel, rd, first;
   int         n;
   initial begin
      {sda_oe, sel, rd, first, rx_byte, sh, tx_sh} = '0;
      n = 0;
   end
   // Start or stop seen while the clock is high
   always @(negedge sda) if (scl) begin
      n = 0;
      first = 1;
      sel = 0;
   end
   always @(posedge sda) if (scl) sel = 0;
   // Eight data bits sampled, master not-acknowledge ends a read
   always @(posedge scl) begin
      if (n < 8) begin
         sh = {sh[6:0], sda};
         n++;
      end else if (n == 9 && sda) sel = 0;
   end
   // Answer on clock fall: acknowledge, then read bits
   always @(negedge scl) begin
      if (n == 8) begin
         n = 9;
         if (first) begin
            sel = (sh[7:1] == ADDR);
            rd = sh[0];
            first = 0;
            tx_sh = tx_byte;
            sda_oe <= sel;
         end else if (sel && !rd) begin
            rx_byte = sh;
            sda_oe <= 1'b1;
         end else sda_oe <= 1'b0;
      end else if (n == 9) begin
         n = 0;
         sda_oe <= sel && rd && !tx_sh[7];
      end else if (n > 0) sda_oe <= sel && rd && !tx_sh[7-n];
   end
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import tws_pkg::*;
   localparam logic [6:0] TADDR = 7'h52;
   logic      clk = 0, link_clk = 0, rst_n = 0;
   logic      wr = 0, clr = 1, sta = 0, sto = 0, ack = 0, en = 1, dwr = 0;
   tws_byte_t din = 8'h00, dout, stat, rx;
   logic      done, wcol, stp, scl_o, scl_oe, sda_o, sda_oe, t_oe;
   logic      mst_scl_oe = 0, mst_sda_oe = 0;
   int        error_cnt = 0, checks = 0;
   wire       scl = !(scl_oe || mst_scl_oe);
   wire       sda = !(sda_oe || t_oe || mst_sda_oe);
   // Clocks
   always #5 clk = ~clk;
   always #24 link_clk = ~link_clk;
   tws_core i_dut (.CLK(clk), .RST_N(rst_n), .LINK_CLK(link_clk), .CTRL_WR(wr),
      .CTRL_CLEAR(clr), .CTRL_START_REQUEST_BIT(sta), .CTRL_STOP(sto), .CTRL_ACK_EN(ack),
      .CTRL_ENABLE(en), .DATA_WR(dwr), .DATA_IN(din), .OWN_ADDR(7'h01), .DATA_OUT(dout),
      .BUS_STATUS_REGISTER(stat), .DONE_FLAG(done), .WRITE_COLLISION_FLAG(wcol),
      .STOP_PENDING(stp), .SCL_I(scl), .SCL_O(scl_o), .SCL_OE(scl_oe), .SDA_I(sda),
      .SDA_O(sda_o), .SDA_OE(sda_oe));
   tws_target_model #(.ADDR(TADDR)) i_tgt (.scl(scl), .sda(sda), .tx_byte(8'h3c),
      .sda_oe(t_oe), .rx_byte(rx));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      if (error_cnt == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic ctrl(input logic s, input logic p, input logic a);
      @(negedge clk);
      {wr, sta, sto, ack} = {1'b1, s, p, a};
      @(negedge clk);
      wr = 0;
   endtask
   task automatic load(input tws_byte_t b);
      @(negedge clk);
      {din, dwr} = {b, 1'b1};
      @(negedge clk);
      dwr = 0;
      @(negedge clk);
   endtask
   // Continue the bus, wait for the flag, compare the masked code
   task automatic step(input logic s, input logic a, input tws_byte_t exp);
      int n;
      ctrl(s, 1'b0, a);
      @(negedge clk);
      check({7'h00, done}, 8'h00);
      for (n = 0; n < 5000 && done !== 1'b1; n++) @(negedge clk);
      check({7'h00, done}, 8'h01);
      check(stat & 8'hf8, exp);
   endtask
   task automatic stop_bus;
      int n;
      ctrl(1'b0, 1'b1, 1'b0);
      check({7'h00, stp}, 8'h01);
      for (n = 0; n < 2000 && stp !== 1'b0; n++) @(negedge clk);
      check({7'h00, stp | done}, 8'h00);
   endtask
   // Second master on the bus, for the slave roles; OE high pulls low
   task automatic mstart;
      mst_sda_oe = 1;
      repeat (50) @(negedge clk);
      mst_scl_oe = 1;
      repeat (25) @(negedge clk);
   endtask
   // Eight bits, then the acknowledge bit; waits while the block holds the clock
   task automatic mbyte(input tws_byte_t b, input logic ack_exp);
      for (int i = 7; i >= -1; i--) begin
         mst_sda_oe = (i >= 0) && !b[i];
         repeat (25) @(negedge clk);
         mst_scl_oe = 0;
         while (!scl) @(negedge clk);
         repeat (50) @(negedge clk);
         if (i < 0) check({7'h00, sda}, {7'h00, !ack_exp});
         mst_scl_oe = 1;
         repeat (25) @(negedge clk);
      end
   endtask
   task automatic mstop;
      mst_sda_oe = 1;
      repeat (25) @(negedge clk);
      mst_scl_oe = 0;
      while (!scl) @(negedge clk);
      repeat (50) @(negedge clk);
      mst_sda_oe = 0;
   endtask
   // Main sequence
   initial begin
      repeat (2) @(posedge link_clk);
      @(negedge clk);
      rst_n = 1;
      check(stat, 8'hf8);
      check({6'h00, scl_o, sda_o}, 8'h00);
      load(8'h11);
      check(dout, 8'h00);
      check({7'h00, wcol}, 8'h01);
      step(1'b1, 1'b0, 8'h08);
      load({TADDR, 1'b0});
      check(dout, {TADDR, 1'b0});
      check({7'h00, wcol}, 8'h00);
      step(1'b0, 1'b0, 8'h18);
      check({7'h00, scl_oe}, 8'h01);
      clr = 0;
      ctrl(1'b0, 1'b0, 1'b0);
      clr = 1;
      check({7'h00, done}, 8'h01);
      load(8'ha5);
      step(1'b0, 1'b0, 8'h28);
      check(rx, 8'ha5);
      stop_bus;
      step(1'b1, 1'b0, 8'h08);
      load({7'h13, 1'b0});
      step(1'b0, 1'b0, 8'h20);
      step(1'b1, 1'b0, 8'h10);
      load({TADDR, 1'b1});
      step(1'b0, 1'b0, 8'h40);
      step(1'b0, 1'b0, 8'h58);
      check(dout, 8'h3c);
      stop_bus;
      mstart;
      mbyte({7'h01, 1'b0}, 1'b1);
      for (int n = 0; n < 5000 && done !== 1'b1; n++) @(negedge clk);
      check(stat, 8'h60);
      fork
         mbyte(8'h5a, 1'b1);
      join_none
      step(1'b0, 1'b1, 8'h80);
      check(dout, 8'h5a);
      fork
         mstop;
      join_none
      step(1'b0, 1'b0, 8'ha0);
      ctrl(1'b0, 1'b0, 1'b0);
      close_out;
   end
   // Watchdog
   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      close_out;
   end
endmodule
